/* src/toc_pkg.sv */
// constants and types of the timer16 output compare unit
// Functional notes
// - each channel compares count to its value; flag sets at next timer tick
// - flag with interrupt enable requests interrupt; service acknowledge clears the flag
// - writing one to a flag bit clears it; zero leaves it
// - channel A compare value can serve as the counter TOP
// - double buffering on in the twelve PWM modes, off otherwise
// - buffered compare value loads into active register at TOP or BOTTOM
// - software writes reach buffer when buffered, active register otherwise
// - only software changes compare value; high byte reads directly
// - high byte first into staging byte; low write moves 16 bits at once
// - force strobe in non-PWM modes acts like a match, no flag
// - count write blocks all matches on the following timer tick
// - count written equal to TOP skips that TOP, counts on to 0xFFFF
// - output state survives mode changes and resets to 0
// - action field is not buffered; next match uses new setting
// - nonzero action field puts output state on pin; direction bit keeps control
// - action field has no effect on capture value logic
// - action value 0 leaves output state unchanged on matches
// - action field never alters counting; selects PWM polarity or set/clear/toggle
// - waveform logic uses TOP and BOTTOM to handle extreme values; the code feeds it only the TOP event, and only in fast PWM
// - mode 0 counts up only, never clears, wraps 0xFFFF to 0x0000
`default_nettype none
package toc_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_FORCE = 12'h004;
   localparam logic [11:0] REG_FLAGS = 12'h008;
   localparam logic [11:0] REG_CNT_LO = 12'h00C;
   localparam logic [11:0] REG_CNT_HI = 12'h010;
   localparam logic [11:0] REG_CMPA_LO = 12'h014;
   localparam logic [11:0] REG_CMPA_HI = 12'h018;
   localparam logic [11:0] REG_CMPB_LO = 12'h01C;
   localparam logic [11:0] REG_CMPB_HI = 12'h020;
   localparam logic [11:0] REG_TOPV_LO = 12'h024;
   localparam logic [11:0] REG_TOPV_HI = 12'h028;
   localparam logic [11:0] REG_PRESC = 12'h02C;
   localparam int CTL_MODE = 0;
   localparam int CTL_ACTA = 4;
   localparam int CTL_RUN = 8;
   localparam int CTL_IENA = 9;
   localparam int CTL_DIRA = 11;
   localparam int CTL_PORTA = 13;
   localparam logic [14:0] CTRL_RST = 15'h0000;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TOP8 = 16'h00FF;
   localparam logic [15:0] TOP9 = 16'h01FF;
   localparam logic [15:0] TOP10 = 16'h03FF;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_A = 4'h4;
   localparam logic [3:0] MODE_CTC_T = 4'hC;
   localparam logic [3:0] MODE_RSVD = 4'hD;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TGL = 2'h1;
   localparam logic [1:0] ACT_CLR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {CNT_UP, CNT_DOWN} toc_dir_type;
endpackage : toc_pkg
`default_nettype wire

/* src/toc_unit.sv */
// output compare unit of a 16-bit timer with an AXI4-Lite register port
`default_nettype none
module toc_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [toc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [toc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_ack_a,
   input wire logic irq_ack_b,
   output logic irq_a,
   output logic irq_b,
   output logic pin_a_out,
   output logic pin_a_oe,
   output logic pin_b_out,
   output logic pin_b_oe
);
   import toc_pkg::*;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= REG_PRESC);
   endfunction : mapped

   // output state after a match, force or TOP event
   function automatic logic oc_next(input logic oc, input logic [1:0] act,
         input logic np, input logic fst, input logic up, input logic m,
         input logic f, input logic t, input logic tg);
      logic k;
      k = fst | ~up;
      oc_next = oc;
      if (act != ACT_NONE) begin
         if (np) begin
            if (m | f) begin
               case (act)
                  ACT_TGL: oc_next = ~oc;
                  ACT_CLR: oc_next = 1'b0;
                  ACT_SET: oc_next = 1'b1;
                  default: oc_next = oc;
               endcase
            end
         end else if (act == ACT_TGL) begin
            if (m & tg) begin
               oc_next = ~oc;
            end
         end else if (m) begin
            oc_next = (act == ACT_CLR) ? k : ~k;
         end else if (t & fst) begin
            oc_next = (act == ACT_SET);
         end
      end
   endfunction : oc_next

   ////////////////////////////////////////////////////////////////////////////
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic aw_full_ff, w_full_ff, wstb_ff;
   logic [11:0] awaddr_ff;
   logic [14:0] wdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [14:0] ctrl_ff;
   logic [7:0] presc_ff, div_ff, temp_ff;
   logic [15:0] cnt_ff, topv_ff;
   logic [15:0] cmp_ff [2];
   logic [15:0] buf_ff [2];
   logic [1:0] flag_ff, oc_ff, irq_ff, pin_ff, oe_ff;
   logic block_ff;
   toc_dir_type dir_ff;

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign irq_a = irq_ff[0];
   assign irq_b = irq_ff[1];
   assign pin_a_out = pin_ff[0];
   assign pin_b_out = pin_ff[1];
   assign pin_a_oe = oe_ff[0];
   assign pin_b_oe = oe_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   wire aw_hs = s_axi_awvalid & awready_ff;
   wire w_hs = s_axi_wvalid & wready_ff;
   wire b_hs = bvalid_ff & s_axi_bready;
   wire ar_hs = s_axi_arvalid & arready_ff;
   wire r_hs = rvalid_ff & s_axi_rready;
   wire do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire wr_ok = do_wr & wstb_ff & mapped(awaddr_ff);
   wire [15:0] wr_word = {temp_ff, wdata_ff[7:0]};

   wire wr_ctrl = wr_ok && (awaddr_ff == REG_CTRL);
   wire wr_force = wr_ok && (awaddr_ff == REG_FORCE);
   wire wr_flags = wr_ok && (awaddr_ff == REG_FLAGS);
   wire wr_cnt_lo = wr_ok && (awaddr_ff == REG_CNT_LO);
   wire wr_topv_lo = wr_ok && (awaddr_ff == REG_TOPV_LO);
   wire wr_presc = wr_ok && (awaddr_ff == REG_PRESC);
   wire wr_hi = wr_ok && ((awaddr_ff == REG_CNT_HI) || (awaddr_ff == REG_CMPA_HI)
      || (awaddr_ff == REG_CMPB_HI) || (awaddr_ff == REG_TOPV_HI));
   wire [1:0] wr_cmp_lo = {wr_ok && (awaddr_ff == REG_CMPB_LO),
      wr_ok && (awaddr_ff == REG_CMPA_LO)};

   ////////////////////////////////////////////////////////////////////////////
   wire [3:0] mode = ctrl_ff[CTL_MODE +: 4];
   wire non_pwm = (mode == MODE_NORMAL) || (mode == MODE_CTC_A)
      || (mode == MODE_CTC_T) || (mode == MODE_RSVD);
   wire pwm = ~non_pwm;
   wire fast = (mode == 4'h5) || (mode == 4'h6) || (mode == 4'h7)
      || (mode == 4'hE) || (mode == 4'hF);
   wire dual = pwm & ~fast;
   wire load_bot = (mode == 4'h8) || (mode == 4'h9);
   wire tgl_a = (mode == 4'hF) || (mode == 4'h9) || (mode == 4'hB);
   wire [15:0] top_val =
      ((mode == 4'h1) || (mode == 4'h5)) ? TOP8 :
      ((mode == 4'h2) || (mode == 4'h6)) ? TOP9 :
      ((mode == 4'h3) || (mode == 4'h7)) ? TOP10 :
      ((mode == 4'h4) || (mode == 4'h9) || (mode == 4'hB) || (mode == 4'hF))
         ? cmp_ff[0] :
      ((mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE))
         ? topv_ff : CNT_MAX;

   // the action field is read live, so a write steers the very next match
   wire [1:0] act [2];
   assign act[0] = ctrl_ff[CTL_ACTA +: 2];
   assign act[1] = ctrl_ff[CTL_ACTA + 2 +: 2];
   wire [1:0] ien = ctrl_ff[CTL_IENA +: 2];
   wire [1:0] pdir = ctrl_ff[CTL_DIRA +: 2];
   wire [1:0] port = ctrl_ff[CTL_PORTA +: 2];
   wire [1:0] ack = {irq_ack_b, irq_ack_a};

   wire tick = ctrl_ff[CTL_RUN] && (div_ff == presc_ff);
   wire at_top = (cnt_ff == top_val);
   wire at_bot = (cnt_ff == VAL_RST);
   wire top_hit = at_top & ~block_ff;
   wire cnt_up = (dir_ff == CNT_UP);
   wire [15:0] cnt_inc = cnt_ff + 16'h0001;
   wire [15:0] cnt_dec = cnt_ff - 16'h0001;
   wire load_pt = tick & (load_bot ? (at_bot & ~block_ff) : top_hit);
   wire [1:0] match = {tick & ~block_ff & (cnt_ff == cmp_ff[1]),
      tick & ~block_ff & (cnt_ff == cmp_ff[0])};
   wire [1:0] force_s = wr_force ? (wdata_ff[1:0] & {2{non_pwm}}) : 2'h0;
   wire [1:0] clr = (wr_flags ? wdata_ff[1:0] : 2'h0) | ack;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_ff <= 1'b0;
         awready_ff <= 1'b1;
         awaddr_ff <= REG_CTRL;
      end else begin
         if (aw_hs) begin
            aw_full_ff <= 1'b1;
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
         end
         if (do_wr) begin
            aw_full_ff <= 1'b0;
         end
         if (b_hs) begin
            awready_ff <= 1'b1;
         end
      end
   end

   // the whole control word is held here: the master may move wdata once it is taken,
   // so nothing later in the write may read the bus lines themselves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_ff <= 1'b0;
         wready_ff <= 1'b1;
         wdata_ff <= 15'h0000;
         wstb_ff <= 1'b0;
      end else begin
         if (w_hs) begin
            w_full_ff <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata[14:0];
            wstb_ff <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            w_full_ff <= 1'b0;
         end
         if (b_hs) begin
            wready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_ff <= 1'b0;
      end
   end

   // compare high bytes bypass the staging byte on reads
   wire [11:0] ra = s_axi_araddr;
   wire [7:0] rd_byte =
      (ra == REG_FLAGS) ? {6'h00, flag_ff} :
      (ra == REG_CNT_LO) ? cnt_ff[7:0] :
      (ra == REG_CNT_HI) ? temp_ff :
      (ra == REG_CMPA_LO) ? buf_ff[0][7:0] :
      (ra == REG_CMPA_HI) ? buf_ff[0][15:8] :
      (ra == REG_CMPB_LO) ? buf_ff[1][7:0] :
      (ra == REG_CMPB_HI) ? buf_ff[1][15:8] :
      (ra == REG_TOPV_LO) ? topv_ff[7:0] :
      (ra == REG_TOPV_HI) ? topv_ff[15:8] :
      (ra == REG_PRESC) ? presc_ff : 8'h00;
   wire [31:0] rd_word = (ra == REG_CTRL) ? {17'h0_0000, ctrl_ff} : {24'h00_0000, rd_byte};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= mapped(ra) ? rd_word : 32'h0000_0000;
         rresp_ff <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // a write wins over the read latch when both hit the staging byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         temp_ff <= 8'h00;
      end else if (wr_hi) begin
         temp_ff <= wdata_ff[7:0];
      end else if (ar_hs && (ra == REG_CNT_LO)) begin
         temp_ff <= cnt_ff[15:8];
      end
   end

   // capture value serves only as a TOP source here, the action field never reaches it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= CTRL_RST;
         presc_ff <= PRESC_RST;
         topv_ff <= VAL_RST;
      end else begin
         // control takes the latched word, one cycle after the data beat
         if (wr_ctrl) begin
            ctrl_ff <= wdata_ff;
         end
         if (wr_presc) begin
            presc_ff <= wdata_ff[7:0];
         end
         if (wr_topv_lo) begin
            topv_ff <= wr_word;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_ff[CTL_RUN] || tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the count write has priority over every count step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= VAL_RST;
         dir_ff <= CNT_UP;
      end else if (wr_cnt_lo) begin
         cnt_ff <= wr_word;
      end else if (tick) begin
         if (dual) begin
            if (cnt_up && top_hit) begin
               dir_ff <= CNT_DOWN;
               cnt_ff <= cnt_dec;
            end else if (!cnt_up && at_bot && !block_ff) begin
               dir_ff <= CNT_UP;
               cnt_ff <= cnt_inc;
            end else begin
               cnt_ff <= cnt_up ? cnt_inc : cnt_dec;
            end
         end else begin
            dir_ff <= CNT_UP;
            cnt_ff <= top_hit ? VAL_RST : cnt_inc;
         end
      end
   end

   // the block waits for a tick, so it also holds while the timer is stopped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_ff <= 1'b0;
      end else if (wr_cnt_lo) begin
         block_ff <= 1'b1;
      end else if (tick) begin
         block_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         if (!aresetn) begin
            buf_ff[i] <= VAL_RST;
            cmp_ff[i] <= VAL_RST;
         end else begin
            if (pwm && load_pt) begin
               cmp_ff[i] <= buf_ff[i];
            end
            if (wr_cmp_lo[i]) begin
               buf_ff[i] <= wr_word;
               if (non_pwm) begin
                  cmp_ff[i] <= wr_word;
               end
            end
         end
      end
   end

   // a new match beats a clear arriving in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ff <= 2'h0;
         irq_ff <= 2'h0;
      end else begin
         flag_ff <= match | (flag_ff & ~clr);
         irq_ff <= flag_ff & ien & ~clr;
      end
   end

   // output state ignores mode writes; only events move it
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         if (!aresetn) begin
            oc_ff[i] <= 1'b0;
            pin_ff[i] <= 1'b0;
            oe_ff[i] <= 1'b0;
         end else begin
            oc_ff[i] <= oc_next(oc_ff[i], act[i], non_pwm, fast, cnt_up,
               match[i], force_s[i], tick & top_hit, (i == 0) && tgl_a);
            pin_ff[i] <= (act[i] != ACT_NONE) ? oc_ff[i] : port[i];
            oe_ff[i] <= pdir[i];
         end
      end
   end
endmodule : toc_unit
`default_nettype wire

/* bench/toc_unit_chk.sv */
// bus and pin checks bound to the output compare unit
`default_nettype none
module toc_unit_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pin_a_out,
   input wire logic pin_b_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   reset_idle_a:
   assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
      && !pin_a_out && !pin_b_out && !pin_a_oe && !pin_b_oe)
      else $error("outputs not idle after reset");
   write_latency_a:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not on second edge");
   read_latency_a:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   write_release_a:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
      && s_axi_wready)
      else $error("write channel not released");
   read_release_a:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released");
   write_busy_a:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_busy_a:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   // direction bits only move on a register write, one cycle after the update
   oe_follow_a:
   assert property ($past(aresetn) && ($changed(pin_a_oe) || $changed(pin_b_oe))
      |-> $past(s_axi_bvalid))
      else $error("pin enable moved without a write");
endmodule : toc_unit_chk
bind toc_unit toc_unit_chk toc_unit_chk_inst (.*);
`default_nettype wire

/* bench/toc_cpu_mdl.sv */
// register bus master standing in for the cpu
`default_nettype none
module toc_cpu_mdl (
   input wire logic aclk,
   output var logic [11:0] s_axi_awaddr,
   output var logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0] s_axi_wstrb,
   output var logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output var logic s_axi_bready,
   output var logic [11:0] s_axi_araddr,
   output var logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output var logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ready lines stay high: every answer is taken at the first edge it shows
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_araddr, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'h1;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      r = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
endmodule : toc_cpu_mdl
`default_nettype wire

/* bench/toc_unit_bench.sv */
// self-checking bench for the timer16 output compare unit
`default_nettype none
module toc_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import toc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic irq_ack_a = 1'b0;
   logic irq_ack_b = 1'b0;
   wire logic [11:0] s_axi_awaddr, s_axi_araddr;
   wire logic [31:0] s_axi_wdata, s_axi_rdata;
   wire logic [3:0] s_axi_wstrb;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   wire logic irq_a, irq_b, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int mdl [0:11];
   int flg = 0;
   int stg = 0;
   logic [15:0] lf = 16'he1ef;
   logic [31:0] d;
   logic [1:0] r;
   toc_unit toc_unit_inst (.*);
   toc_cpu_mdl toc_cpu_mdl_inst (.*);
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction : rnd
   // count is not modelled: it is only read while still at its reset value
   function automatic logic [31:0] exp_rd(input logic [11:0] a);
      case (a)
         REG_CTRL: return mdl[0];
         REG_FLAGS: return flg;
         REG_PRESC: return mdl[11];
         REG_CMPA_LO, REG_CMPB_LO, REG_TOPV_LO: return mdl[a >> 2] & 255;
         REG_CMPA_HI, REG_CMPB_HI, REG_TOPV_HI: return mdl[(a >> 2) - 1] >> 8;
         default: return 0;
      endcase
   endfunction : exp_rd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input int v);
      toc_cpu_mdl_inst.wr(a, v, r);
      chk(r, RESP_OKAY);
      case (a)
         REG_CTRL: mdl[0] = v & 32'h0000_7fff;
         REG_FLAGS: flg = flg & ~v;
         REG_PRESC: mdl[11] = v & 255;
         REG_CNT_HI, REG_CMPA_HI, REG_CMPB_HI, REG_TOPV_HI: stg = v & 255;
         REG_CMPA_LO, REG_CMPB_LO, REG_TOPV_LO: mdl[a >> 2] = (stg << 8) | (v & 255);
         default: ;
      endcase
   endtask : wr
   task automatic rdc(input logic [11:0] a);
      toc_cpu_mdl_inst.rd(a, d, r);
      chk(d, exp_rd(a));
      chk(r, (a > 12'h02c || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY);
   endtask : rdc
   task automatic w16(input logic [11:0] lo, input int v);
      wr(lo + 12'h004, v >> 8);
      wr(lo, v);
   endtask : w16
   task automatic poll(input int want);
      d = '0;
      for (int i = 0; i < 400 && d[1:0] != want[1:0]; i++) toc_cpu_mdl_inst.rd(REG_FLAGS, d, r);
      flg = want;
   endtask : poll
   task automatic test_done();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      static int acts [5] = '{ACT_CLR, ACT_TGL, ACT_TGL, ACT_SET, ACT_NONE};
      int o;
      int p;
      logic [15:0] v;
      o = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a <= 48; a += 4) rdc(12'(a));
      rdc(12'h00e);
      v = rnd();
      wr(REG_CMPA_HI, v >> 8);
      rdc(REG_CMPA_HI);
      rdc(REG_CMPA_LO);
      wr(REG_CMPA_LO, v);
      rdc(REG_CMPA_HI);
      rdc(REG_CMPA_LO);
      // output state set up before any timer activity
      for (int i = 0; i < 5; i++) begin
         p = rnd() & 1;
         wr(REG_CTRL, (1 << CTL_DIRA) | (p << CTL_PORTA) | (acts[i] << CTL_ACTA));
         wr(REG_FORCE, 1);
         case (acts[i])
            ACT_TGL: o = 1 - o;
            ACT_CLR: o = 0;
            ACT_SET: o = 1;
            default: ;
         endcase
         repeat (2) @(posedge aclk);
         chk(pin_a_out, (acts[i] != 0) ? o : p);
         chk(pin_a_oe, 1);
         chk({pin_b_oe, pin_b_out}, 0);
      end
      rdc(REG_FLAGS);
      wr(REG_CTRL, (1 << CTL_DIRA) | (ACT_SET << CTL_ACTA) | 5);
      repeat (2) @(posedge aclk);
      chk(pin_a_out, o);
      wr(REG_CTRL, 0);
      wr(REG_PRESC, rnd() & 3);
      w16(REG_CMPA_LO, 16'h0090);
      w16(REG_CMPB_LO, 16'h0040);
      w16(REG_CNT_LO, 16'h0040);
      wr(REG_CTRL, (1 << CTL_RUN) | MODE_CTC_A);
      repeat (40) @(posedge aclk);
      rdc(REG_FLAGS);
      poll(3);
      wr(REG_CTRL, 0);
      rdc(REG_FLAGS);
      wr(REG_FLAGS, 0);
      rdc(REG_FLAGS);
      wr(REG_FLAGS, 1);
      rdc(REG_FLAGS);
      wr(REG_CTRL, 1 << (CTL_IENA + 1));
      repeat (2) @(posedge aclk);
      chk(irq_b, 1);
      chk(irq_a, 0);
      irq_ack_a <= 1'b1;
      irq_ack_b <= 1'b1;
      @(posedge aclk);
      irq_ack_a <= 1'b0;
      irq_ack_b <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(irq_b, 0);
      flg = 0;
      rdc(REG_FLAGS);
      // pwm mode: the new compare value must wait in the buffer until top
      wr(REG_CTRL, 5);
      wr(REG_PRESC, 0);
      w16(REG_CMPB_LO, 16'h0010);
      w16(REG_CNT_LO, 16'h0005);
      wr(REG_CTRL, 5 | (1 << CTL_RUN));
      repeat (40) @(posedge aclk);
      rdc(REG_FLAGS);
      poll(3);
      wr(REG_CTRL, 5);
      rdc(REG_FLAGS);
      rdc(REG_CMPB_LO);
      test_done();
   end
endmodule : toc_unit_bench
`default_nettype wire
